/* ttm_pkg.sv */
// Constants, register layout and encodings for the transaction timer manager.
package ttm_pkg;

  localparam int NUM_TIMERS = 7;

  // Timer numbers of the transmit sources.
  localparam logic [2:0] TMR_DATA_TX = 3'h0;
  localparam logic [2:0] TMR_DATA_RX = 3'h1;
  localparam logic [2:0] TMR_ASYNC_TX = 3'h2;
  localparam logic [2:0] TMR_MGMT_Q = 3'h3;
  localparam logic [2:0] TMR_CMD_Q = 3'h4;
  localparam logic [2:0] TMR_UNUSED = 3'h5;
  localparam logic [2:0] TMR_AUTO_RESP = 3'h6;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h60;
  localparam logic [7:0] ADDR_STAT1 = 8'h64;
  localparam logic [7:0] ADDR_STAT2 = 8'h68;
  localparam logic [7:0] ADDR_STAT3 = 8'h6C;

  // Control register fields; per-source flags sit at MSB minus timer number.
  localparam int CTRL_DONE_MSB = 31;
  localparam int CTRL_FAIL_MSB = 23;
  localparam int CTRL_RETRY_MSB = 15;
  localparam int CTRL_CANCEL_BIT = 7;
  localparam int CTRL_SUSPEND_BIT = 6;
  localparam int CTRL_RESUME_BIT = 5;
  localparam int CTRL_SEL_LSB = 0;
  localparam logic [2:0] CTRL_SEL_RST = 3'h0;

  // Status register fields.
  localparam int STAT1_DEST_ID_LSB = 16;
  localparam int STAT1_OFFS_HI_LSB = 0;
  localparam int STAT3_TCODE_LSB = 28;
  localparam int STAT3_SPD_LSB = 24;
  localparam int STAT3_TLABEL_LSB = 18;
  localparam int STAT3_RETRY_LSB = 14;
  localparam int STAT3_SPLIT_LSB = 0;

  // Busy retries allowed before the transaction is given up.
  localparam logic [3:0] RETRY_LIMIT = 4'h3;

  // Split transaction timeout.
  localparam int CLK_MHZ = 25;
  localparam int SPLIT_TIMEOUT_US = 100000;
  localparam logic [21:0] SPLIT_TIMEOUT_CYC = 22'(SPLIT_TIMEOUT_US * CLK_MHZ);

  typedef enum logic [1:0] {
    ACK_COMPLETE = 2'b00,
    ACK_PENDING = 2'b01,
    ACK_BUSY = 2'b10,
    ACK_ERROR = 2'b11
  } ttm_ack_t;

  typedef enum logic [1:0] {
    RSP_OK = 2'b00,
    RSP_ERROR = 2'b01,
    RSP_BUSY_EXHAUSTED = 2'b10,
    RSP_SPLIT_TIMEOUT = 2'b11
  } ttm_rsp_status_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEND = 3'b001,
    ST_WAIT_ACK = 3'b010,
    ST_SPLIT = 3'b011,
    ST_HELD = 3'b100
  } ttm_state_t;

endpackage

/* ttm_remote_node.sv */
// Remote node model: takes a request after a set delay and acknowledges it a cycle later.
`timescale 1ns/1ps
module ttm_remote_node
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Behaviour chosen by the bench.
  input wire logic [7:0] accept_delay,
  input wire ttm_pkg::ttm_ack_t ack_mode,
  // Request side.
  input wire logic tx_valid,
  input wire logic [2:0] tx_timer,
  output logic tx_ready,
  // Acknowledge side.
  output logic ack_valid,
  output logic [2:0] ack_timer,
  output ttm_pkg::ttm_ack_t ack_code
);
  import ttm_pkg::*;
  logic [7:0] wait_cnt;
  assign tx_ready = tx_valid && (wait_cnt >= accept_delay);
  // Outside an acknowledge the fields toggle so that a stale value is never mistaken for a fresh one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 8'h00;
      ack_valid <= 1'b0;
      ack_timer <= 3'h0;
      ack_code <= ACK_COMPLETE;
    end
    else
    begin
      wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 8'h01 : 8'h00;
      ack_valid <= tx_valid && tx_ready;
      ack_timer <= (tx_valid && tx_ready) ? tx_timer : ~ack_timer;
      ack_code <= (tx_valid && tx_ready) ? ack_mode : ttm_ack_t'(~ack_code);
    end
  end
endmodule

/* ttm_txn_monitor.sv */
// Port checker for the transaction timer manager.
`timescale 1ns/1ps
module ttm_txn_monitor
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // Launch and link side.
  input wire logic [ttm_pkg::NUM_TIMERS-1:0] launch_valid,
  input wire logic [ttm_pkg::NUM_TIMERS-1:0] launch_ready,
  input wire logic tx_valid,
  input wire logic ack_valid,
  input wire logic [2:0] ack_timer,
  input wire ttm_pkg::ttm_ack_t ack_code,
  input wire logic bus_reset,
  // Response FIFO.
  input wire logic rfifo_wr,
  input wire logic [2:0] rfifo_timer,
  input wire ttm_pkg::ttm_rsp_status_t rfifo_status
);
  import ttm_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_launch;
    |(launch_valid & launch_ready);
  endsequence
  sequence s_ack_ok;
    ack_valid && ack_code == ACK_COMPLETE;
  endsequence
  // The timer number is taken from the acknowledge cycle in both steps, as the link side moves on after it.
  sequence s_split_held;
    !launch_ready[$past(ack_timer)] ##1 !launch_ready[$past(ack_timer, 2)];
  endsequence
  chk_launch_busy: assert property (s_launch |=> tx_valid && (launch_ready & $past(launch_valid)) == 7'h00)
    else $error("launch not taken");
  chk_ack_ok_entry: assert property (s_ack_ok |=> rfifo_wr && rfifo_timer == $past(ack_timer) && rfifo_status == RSP_OK)
    else $error("no ok entry");
  chk_ack_err_entry: assert property (ack_valid && ack_code == ACK_ERROR |=> rfifo_wr && rfifo_status == RSP_ERROR)
    else $error("no error entry");
  chk_entry_idle: assert property (rfifo_wr |-> launch_ready[rfifo_timer])
    else $error("entry while busy");
  chk_no_slot_five: assert property (!launch_ready[5] && !(rfifo_wr && rfifo_timer == TMR_UNUSED))
    else $error("timer five used");
  chk_bus_reset_idle: assert property (bus_reset |=> launch_ready == 7'h5F)
    else $error("bus reset left a timer");
  chk_busy_retry: assert property (ack_valid && ack_code == ACK_BUSY |=> tx_valid || rfifo_wr)
    else $error("busy not handled");
  chk_pending_wait: assert property (ack_valid && ack_code == ACK_PENDING |=> s_split_held)
    else $error("split wait ended");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
endmodule
bind ttm_txn_timer ttm_txn_monitor u_mon (.pclk, .presetn, .psel, .penable, .pslverr, .launch_valid, .launch_ready,
  .tx_valid, .ack_valid, .ack_timer, .ack_code, .bus_reset, .rfifo_wr, .rfifo_timer, .rfifo_status);

/* ttm_txn_timer.sv */
// Transaction timer manager: supervises outbound transactions of all transmit sources.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module ttm_txn_timer
#(
  parameter logic [21:0] SPLIT_TIMEOUT = ttm_pkg::SPLIT_TIMEOUT_CYC
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Launch from the transmit sources, one-hot by timer number.
  input wire logic [ttm_pkg::NUM_TIMERS-1:0] launch_valid,
  output logic [ttm_pkg::NUM_TIMERS-1:0] launch_ready,
  input wire logic [15:0] launch_dest_id,
  input wire logic [15:0] launch_offset_hi,
  input wire logic [31:0] launch_offset_lo,
  input wire logic [3:0] launch_tcode,
  input wire logic [2:0] launch_spd,
  input wire logic [5:0] launch_tlabel,
  // Request toward the link transmitter.
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [2:0] tx_timer,
  output logic [15:0] tx_dest_id,
  output logic [47:0] tx_offset,
  output logic [3:0] tx_tcode,
  output logic [2:0] tx_spd,
  output logic [5:0] tx_tlabel,
  // Acknowledge and response from remote nodes.
  input wire logic ack_valid,
  input wire logic [2:0] ack_timer,
  input wire ttm_pkg::ttm_ack_t ack_code,
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_timer,
  input wire logic [3:0] rsp_rcode,
  input wire logic bus_reset,
  // Response FIFO write port.
  output logic rfifo_wr,
  output logic [2:0] rfifo_timer,
  output ttm_pkg::ttm_rsp_status_t rfifo_status,
  output logic [3:0] rfifo_rcode
);
  import ttm_pkg::*;

  localparam int NT = NUM_TIMERS;

  ttm_state_t state_ff [NT];
  ttm_state_t nxt_state [NT];
  logic [15:0] dest_id_ff [NT];
  logic [15:0] nxt_dest_id [NT];
  logic [47:0] offset_ff [NT];
  logic [47:0] nxt_offset [NT];
  logic [3:0] tcode_ff [NT];
  logic [3:0] nxt_tcode [NT];
  logic [2:0] spd_ff [NT];
  logic [2:0] nxt_spd [NT];
  logic [5:0] tlabel_ff [NT];
  logic [5:0] nxt_tlabel [NT];
  logic [3:0] retry_cnt_ff [NT];
  logic [3:0] nxt_retry_cnt [NT];
  logic [21:0] split_cnt_ff [NT];
  logic [21:0] nxt_split_cnt [NT];
  logic [NT-1:0] done_ff, nxt_done;
  logic [NT-1:0] fail_ff, nxt_fail;
  logic [NT-1:0] retrying_ff, nxt_retrying;
  logic rfifo_wr_ff, nxt_rfifo_wr;
  logic [2:0] rfifo_timer_ff, nxt_rfifo_timer;
  ttm_rsp_status_t rfifo_status_ff, nxt_rfifo_status;
  logic [3:0] rfifo_rcode_ff, nxt_rfifo_rcode;

  logic [2:0] sel_ff, nxt_sel;
  logic cancel_ff, nxt_cancel;
  logic suspend_ff, nxt_suspend;
  logic resume_ff, nxt_resume;
  logic [2:0] cmd_tmr_ff, nxt_cmd_tmr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;

  logic [2:0] grant;
  logic any_send;

  // Timer 5 has no source behind it.
  function automatic logic timer_exists(input logic [2:0] t);
    return (t != TMR_UNUSED) && (t < 3'(NT));
  endfunction

  // Lowest numbered source waiting to send gets the transmitter.
  always_comb
  begin
    grant = 3'h0;
    any_send = 1'b0;
    for (int i = NT - 1; i >= 0; i--)
    begin
      if (state_ff[i] == ST_SEND)
      begin
        grant = 3'(i);
        any_send = 1'b1;
      end
    end
  end

  assign tx_valid = any_send;
  assign tx_timer = grant;
  assign tx_dest_id = dest_id_ff[grant];
  assign tx_offset = offset_ff[grant];
  assign tx_tcode = tcode_ff[grant];
  assign tx_spd = spd_ff[grant];
  assign tx_tlabel = tlabel_ff[grant];

  // Per-timer transaction sequencing.
  always_comb
  begin
    logic fin;
    logic slot_used;
    ttm_rsp_status_t fin_st;
    logic [3:0] fin_rc;
    fin = 1'b0;
    fin_st = RSP_OK;
    fin_rc = 4'h0;
    slot_used = 1'b0;
    nxt_rfifo_wr = 1'b0;
    nxt_rfifo_timer = rfifo_timer_ff;
    nxt_rfifo_status = rfifo_status_ff;
    nxt_rfifo_rcode = rfifo_rcode_ff;
    nxt_done = done_ff;
    nxt_fail = fail_ff;
    nxt_retrying = retrying_ff;
    for (int i = 0; i < NT; i++)
    begin
      fin = 1'b0;
      fin_st = RSP_OK;
      fin_rc = 4'h0;
      nxt_state[i] = state_ff[i];
      nxt_dest_id[i] = dest_id_ff[i];
      nxt_offset[i] = offset_ff[i];
      nxt_tcode[i] = tcode_ff[i];
      nxt_spd[i] = spd_ff[i];
      nxt_tlabel[i] = tlabel_ff[i];
      nxt_retry_cnt[i] = retry_cnt_ff[i];
      nxt_split_cnt[i] = split_cnt_ff[i];
      launch_ready[i] = timer_exists(3'(i)) && (state_ff[i] == ST_IDLE);
      if (state_ff[i] != ST_IDLE && (bus_reset || (cancel_ff && cmd_tmr_ff == 3'(i))))
      begin
        // Removed transactions end as failed but leave no response entry.
        nxt_state[i] = ST_IDLE;
        nxt_done[i] = 1'b1;
        nxt_fail[i] = 1'b1;
        nxt_retrying[i] = 1'b0;
      end
      else
      begin
        case (state_ff[i])
          ST_IDLE:
          begin
            if (launch_valid[i] && launch_ready[i])
            begin
              nxt_state[i] = ST_SEND;
              nxt_dest_id[i] = launch_dest_id;
              nxt_offset[i] = {launch_offset_hi, launch_offset_lo};
              nxt_tcode[i] = launch_tcode;
              nxt_spd[i] = launch_spd;
              nxt_tlabel[i] = launch_tlabel;
              nxt_retry_cnt[i] = 4'h0;
              nxt_split_cnt[i] = 22'h0;
              nxt_done[i] = 1'b0;
              nxt_fail[i] = 1'b0;
              nxt_retrying[i] = 1'b0;
            end
          end
          ST_SEND:
          begin
            if (suspend_ff && cmd_tmr_ff == 3'(i))
            begin
              nxt_state[i] = ST_HELD;
            end
            else if (tx_ready && grant == 3'(i))
            begin
              nxt_state[i] = ST_WAIT_ACK;
            end
          end
          ST_HELD:
          begin
            if (resume_ff && cmd_tmr_ff == 3'(i))
            begin
              nxt_state[i] = ST_SEND;
            end
          end
          ST_WAIT_ACK:
          begin
            if (ack_valid && ack_timer == 3'(i))
            begin
              case (ack_code)
                ACK_COMPLETE:
                begin
                  fin = 1'b1;
                end
                ACK_PENDING:
                begin
                  nxt_state[i] = ST_SPLIT;
                  nxt_retrying[i] = 1'b0;
                  nxt_split_cnt[i] = 22'h0;
                end
                ACK_BUSY:
                begin
                  if (retry_cnt_ff[i] < RETRY_LIMIT)
                  begin
                    nxt_retry_cnt[i] = retry_cnt_ff[i] + 4'h1;
                    nxt_retrying[i] = 1'b1;
                    nxt_state[i] = ST_SEND;
                  end
                  else
                  begin
                    fin = 1'b1;
                    fin_st = RSP_BUSY_EXHAUSTED;
                  end
                end
                default:
                begin
                  fin = 1'b1;
                  fin_st = RSP_ERROR;
                end
              endcase
            end
          end
          ST_SPLIT:
          begin
            if (rsp_valid && rsp_timer == 3'(i))
            begin
              fin = 1'b1;
              fin_rc = rsp_rcode;
              fin_st = (rsp_rcode == 4'h0) ? RSP_OK : RSP_ERROR;
            end
            else if (split_cnt_ff[i] >= SPLIT_TIMEOUT - 22'h1)
            begin
              // A timeout waits while the FIFO port is busy with another end.
              if (!ack_valid && !rsp_valid && !slot_used)
              begin
                fin = 1'b1;
                fin_st = RSP_SPLIT_TIMEOUT;
              end
            end
            else
            begin
              nxt_split_cnt[i] = split_cnt_ff[i] + 22'h1;
            end
          end
          default:
          begin
            nxt_state[i] = ST_IDLE;
          end
        endcase
      end
      if (fin)
      begin
        slot_used = 1'b1;
        nxt_state[i] = ST_IDLE;
        nxt_done[i] = 1'b1;
        nxt_fail[i] = (fin_st != RSP_OK);
        nxt_retrying[i] = 1'b0;
        nxt_rfifo_wr = 1'b1;
        nxt_rfifo_timer = 3'(i);
        nxt_rfifo_status = fin_st;
        nxt_rfifo_rcode = fin_rc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NT; i++)
      begin
        state_ff[i] <= ST_IDLE;
        dest_id_ff[i] <= 16'h0;
        offset_ff[i] <= 48'h0;
        tcode_ff[i] <= 4'h0;
        spd_ff[i] <= 3'h0;
        tlabel_ff[i] <= 6'h0;
        retry_cnt_ff[i] <= 4'h0;
        split_cnt_ff[i] <= 22'h0;
      end
      done_ff <= {NT{1'b1}};
      fail_ff <= {NT{1'b0}};
      retrying_ff <= {NT{1'b0}};
      rfifo_wr_ff <= 1'b0;
      rfifo_timer_ff <= 3'h0;
      rfifo_status_ff <= RSP_OK;
      rfifo_rcode_ff <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
      begin
        state_ff[i] <= nxt_state[i];
        dest_id_ff[i] <= nxt_dest_id[i];
        offset_ff[i] <= nxt_offset[i];
        tcode_ff[i] <= nxt_tcode[i];
        spd_ff[i] <= nxt_spd[i];
        tlabel_ff[i] <= nxt_tlabel[i];
        retry_cnt_ff[i] <= nxt_retry_cnt[i];
        split_cnt_ff[i] <= nxt_split_cnt[i];
      end
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      retrying_ff <= nxt_retrying;
      rfifo_wr_ff <= nxt_rfifo_wr;
      rfifo_timer_ff <= nxt_rfifo_timer;
      rfifo_status_ff <= nxt_rfifo_status;
      rfifo_rcode_ff <= nxt_rfifo_rcode;
    end
  end

  assign rfifo_wr = rfifo_wr_ff;
  assign rfifo_timer = rfifo_timer_ff;
  assign rfifo_status = rfifo_status_ff;
  assign rfifo_rcode = rfifo_rcode_ff;

  // APB register file; read data is captured in the setup cycle so it comes from flops.
  always_comb
  begin
    logic [31:0] rd;
    logic [2:0] s;
    rd = 32'h0;
    s = sel_ff;
    nxt_sel = sel_ff;
    nxt_cancel = 1'b0;
    nxt_suspend = 1'b0;
    nxt_resume = 1'b0;
    nxt_cmd_tmr = cmd_tmr_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (psel && !penable)
    begin
      nxt_pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_STAT1 || paddr == ADDR_STAT2 || paddr == ADDR_STAT3);
      case (paddr)
        ADDR_CTRL:
        begin
          for (int i = 0; i < NT; i++)
          begin
            if (timer_exists(3'(i)))
            begin
              rd[CTRL_DONE_MSB - i] = done_ff[i];
              rd[CTRL_FAIL_MSB - i] = fail_ff[i];
              rd[CTRL_RETRY_MSB - i] = retrying_ff[i];
            end
          end
          rd[CTRL_SEL_LSB +: 3] = sel_ff;
        end
        ADDR_STAT1:
        begin
          if (timer_exists(s))
          begin
            rd[STAT1_DEST_ID_LSB +: 16] = dest_id_ff[s];
            rd[STAT1_OFFS_HI_LSB +: 16] = offset_ff[s][47:32];
          end
        end
        ADDR_STAT2:
        begin
          if (timer_exists(s))
          begin
            rd = offset_ff[s][31:0];
          end
        end
        ADDR_STAT3:
        begin
          if (timer_exists(s))
          begin
            rd[STAT3_TCODE_LSB +: 4] = tcode_ff[s];
            rd[STAT3_SPD_LSB +: 3] = spd_ff[s];
            rd[STAT3_TLABEL_LSB +: 6] = tlabel_ff[s];
            rd[STAT3_RETRY_LSB +: 4] = retry_cnt_ff[s];
            rd[STAT3_SPLIT_LSB +: 14] = split_cnt_ff[s][21:8];
          end
        end
        default:
        begin
          rd = 32'h0;
        end
      endcase
      nxt_prdata = rd;
    end
    if (psel && penable && pwrite && paddr == ADDR_CTRL)
    begin
      // Commands use the timer number written in the same access.
      nxt_sel = pwdata[CTRL_SEL_LSB +: 3];
      nxt_cmd_tmr = pwdata[CTRL_SEL_LSB +: 3];
      nxt_cancel = pwdata[CTRL_CANCEL_BIT];
      nxt_suspend = pwdata[CTRL_SUSPEND_BIT];
      nxt_resume = pwdata[CTRL_RESUME_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_ff <= CTRL_SEL_RST;
      cancel_ff <= 1'b0;
      suspend_ff <= 1'b0;
      resume_ff <= 1'b0;
      cmd_tmr_ff <= 3'h0;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      sel_ff <= nxt_sel;
      cancel_ff <= nxt_cancel;
      suspend_ff <= nxt_suspend;
      resume_ff <= nxt_resume;
      cmd_tmr_ff <= nxt_cmd_tmr;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;

endmodule

/* ttm_txn_timer_tb.sv */
// Self-checking testbench for the transaction timer manager.
`timescale 1ns/1ps
module ttm_txn_timer_tb;
  import ttm_pkg::*;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
  logic [7:0] paddr = 8'h00, accept_delay = 8'h02;
  logic [31:0] pwdata = 32'h0, prdata, rdat, launch_offset_lo = 32'h0;
  logic [6:0] launch_valid = 7'h00, launch_ready;
  logic [15:0] launch_dest_id = 16'h0, launch_offset_hi = 16'h0, tx_dest_id;
  logic [47:0] tx_offset;
  logic [3:0] launch_tcode = 4'h0, rsp_rcode = 4'h0, rfifo_rcode, last_rcode, tx_tcode;
  logic [2:0] launch_spd = 3'h0, tx_timer, ack_timer, rsp_timer = 3'h0, rfifo_timer, last_timer, tx_spd;
  logic [5:0] launch_tlabel = 6'h0, tx_tlabel;
  logic tx_valid, tx_ready, ack_valid, rsp_valid = 1'b0, bus_reset = 1'b0, rfifo_wr;
  ttm_ack_t ack_code, ack_mode = ACK_COMPLETE;
  ttm_rsp_status_t rfifo_status, last_status;
  int fails = 0, total_checks = 0, n_wr = 0, n_tx = 0, w0, x0;
  ttm_txn_timer #(.SPLIT_TIMEOUT(22'h32)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .launch_valid, .launch_ready, .launch_dest_id, .launch_offset_hi, .launch_offset_lo,
    .launch_tcode, .launch_spd, .launch_tlabel, .tx_valid, .tx_ready, .tx_timer, .tx_dest_id, .tx_offset,
    .tx_tcode, .tx_spd, .tx_tlabel, .ack_valid, .ack_timer, .ack_code, .rsp_valid, .rsp_timer, .rsp_rcode,
    .bus_reset, .rfifo_wr, .rfifo_timer, .rfifo_status, .rfifo_rcode);
  ttm_remote_node u_node (.pclk, .presetn, .accept_delay, .ack_mode, .tx_valid, .tx_timer, .tx_ready, .ack_valid,
    .ack_timer, .ack_code);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Counting on the falling edge keeps the tallies clear of the tasks that poll them at the rising edge.
  always @(negedge pclk)
  begin
    if (rfifo_wr === 1'b1)
    begin
      n_wr++;
      last_timer = rfifo_timer;
      last_status = rfifo_status;
      last_rcode = rfifo_rcode;
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      n_tx++;
  end
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      fails++;
      end_sim();
    end
  endtask
  task launch(input logic [2:0] t);
    @(posedge pclk);
    launch_valid <= 7'h01 << t;
    launch_dest_id <= 16'hFFC0 + 16'(t);
    launch_offset_hi <= 16'h0F00 + 16'(t);
    launch_offset_lo <= 32'hF0000400 + 32'(t);
    launch_tcode <= 4'h4;
    launch_spd <= 3'h2;
    launch_tlabel <= 6'h10 + 6'(t);
    @(posedge pclk);
    launch_valid <= 7'h00;
  endtask
  task wait_cnt(input int lim, input bit on_tx, input int n);
    int i;
    for (i = 0; i < lim && (on_tx ? n_tx < n : n_wr == n); i++)
      @(posedge pclk);
    if (i == lim)
    begin
      fails++;
      end_sim();
    end
  endtask
  task t_reset();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, 32'hFA000000);
    apb(1'b0, 8'h70, 32'h0);
    chk(perr, 1'b1);
    $display("test reset done");
  endtask
  task t_complete();
    accept_delay <= 8'h08;
    w0 = n_wr;
    launch(3'h4);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h08000000, 32'h0);
    chk({tx_dest_id, tx_offset[47:32]}, 32'hFFC40F04);
    chk(tx_offset[31:0], 32'hF0000404);
    chk({tx_valid, tx_timer, tx_tcode, tx_spd, tx_tlabel}, {1'b1, TMR_CMD_Q, 4'h4, 3'h2, 6'h14});
    wait_cnt(100, 1'b0, w0);
    chk({last_timer, last_status}, {TMR_CMD_Q, RSP_OK});
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b1, ADDR_STAT1, 32'h0);
    apb(1'b0, ADDR_STAT1, 32'h0);
    chk(rdat, 32'hFFC40F04);
    apb(1'b0, ADDR_STAT2, 32'h0);
    chk(rdat, 32'hF0000404);
    apb(1'b0, ADDR_STAT3, 32'h0);
    chk(rdat & 32'hF7FFC000, 32'h42500000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, 32'hFA000004);
    apb(1'b1, ADDR_CTRL, 32'h5);
    apb(1'b0, ADDR_STAT1, 32'h0);
    chk(rdat, 32'h0);
    ack_mode <= ACK_ERROR;
    w0 = n_wr;
    launch(3'h4);
    wait_cnt(100, 1'b0, w0);
    chk(last_status, RSP_ERROR);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h08080000, 32'h08080000);
    $display("test complete done");
  endtask
  task t_busy();
    ack_mode <= ACK_BUSY;
    accept_delay <= 8'h06;
    w0 = n_wr;
    x0 = n_tx;
    launch(3'h0);
    wait_cnt(100, 1'b1, x0 + 2);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h80008000, 32'h00008000);
    wait_cnt(200, 1'b0, w0);
    chk(n_tx - x0, 4);
    chk({last_timer, last_status}, {TMR_DATA_TX, RSP_BUSY_EXHAUSTED});
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_STAT3, 32'h0);
    chk(rdat & 32'h0003C000, 32'h0000C000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h80800000, 32'h80800000);
    $display("test busy done");
  endtask
  task t_split();
    ack_mode <= ACK_PENDING;
    accept_delay <= 8'h02;
    w0 = n_wr;
    launch(3'h2);
    wait_cnt(50, 1'b1, n_tx + 1);
    repeat (3) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h20002000, 32'h0);
    wait_cnt(200, 1'b0, w0);
    chk({last_timer, last_status}, {TMR_ASYNC_TX, RSP_SPLIT_TIMEOUT});
    w0 = n_wr;
    launch(3'h3);
    wait_cnt(50, 1'b1, n_tx + 1);
    repeat (3) @(posedge pclk);
    rsp_valid <= 1'b1;
    rsp_timer <= 3'h3;
    @(posedge pclk);
    rsp_valid <= 1'b0;
    wait_cnt(20, 1'b0, w0);
    chk({last_timer, last_status, last_rcode}, {TMR_MGMT_Q, RSP_OK, 4'h0});
    w0 = n_wr;
    launch(3'h3);
    wait_cnt(50, 1'b1, n_tx + 1);
    repeat (3) @(posedge pclk);
    rsp_valid <= 1'b1;
    rsp_rcode <= 4'hA;
    @(posedge pclk);
    rsp_valid <= 1'b0;
    wait_cnt(20, 1'b0, w0);
    chk({last_timer, last_status, last_rcode}, {TMR_MGMT_Q, RSP_ERROR, 4'hA});
    $display("test split done");
  endtask
  task t_cancel();
    ack_mode <= ACK_COMPLETE;
    accept_delay <= 8'h3C;
    w0 = n_wr;
    launch(3'h6);
    apb(1'b1, ADDR_CTRL, 32'h46);
    repeat (3) @(posedge pclk);
    chk(tx_valid, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h020200E7, 32'h00000006);
    apb(1'b1, ADDR_CTRL, 32'h26);
    repeat (2) @(posedge pclk);
    chk(tx_valid, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h86);
    repeat (3) @(posedge pclk);
    chk(tx_valid, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h020200E7, 32'h02020006);
    repeat (10) @(posedge pclk);
    chk(n_wr, w0);
    $display("test cancel done");
  endtask
  task t_busreset();
    w0 = n_wr;
    launch(3'h1);
    repeat (3) @(posedge pclk);
    bus_reset <= 1'b1;
    @(posedge pclk);
    bus_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(tx_valid, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat & 32'h40400000, 32'h40400000);
    chk(n_wr, w0);
    $display("test bus reset done");
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_complete();
    t_busy();
    t_split();
    t_cancel();
    t_busreset();
    end_sim();
  end
endmodule
